// file: dv/lsl_link_checker.sv
`timescale 1ns/1ps
module lsl_link_checker #(
    parameter int RST_CYC = 50
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // device end
    input wire logic dev_dp,
    input wire logic dev_dm,
    input wire logic dev_oe,
    input wire logic dev_pu_dp,
    input wire logic dev_pu_dm,
    // remote end
    input wire logic rem_dp,
    input wire logic rem_dm,
    input wire logic rem_oe
);
    logic [1:0]  jst;
    logic [1:0]  dln;
    logic [19:0] run_d;
    logic [19:0] run_q;

    // idle level set by the pull-ups is the J level
    assign jst = {dev_pu_dp, dev_pu_dm};
    assign dln = {dev_dp, dev_dm};

    // length of the remote end's current SE0 drive
    always_comb begin
        run_d = (rem_oe && !rem_dp && !rem_dm) ? run_q + 20'h1 : 20'h0;
        if (sys_rst_in) begin
            run_d = 20'h0;
        end
    end
    always_ff @(posedge clk_in) begin
        run_q <= run_d;
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    a_sop_k_level: assert property ($rose(dev_oe) |-> dln == ~jst)
        else $error("packet does not open with K");
    a_dev_no_se1: assert property (dev_oe |-> dln != 2'h3)
        else $error("device drives both lines high");
    a_rem_no_se1: assert property (rem_oe |-> {rem_dp, rem_dm} != 2'h3)
        else $error("remote drives both lines high");
    a_rem_k_pol: assert property ($rose(rem_oe) && (rem_dp || rem_dm)
        |-> {rem_dp, rem_dm} == ~jst)
        else $error("remote K polarity differs from attached speed");
    a_fs_eop_j: assert property ($fell(dev_oe) && dev_pu_dp |-> $past(dln, 1) == jst
        && $past(dln, 3) == jst && $past(dln, 4) == 2'h0)
        else $error("full-speed EOP J width wrong");
    a_fs_eop_se0: assert property ($fell(dev_oe) && dev_pu_dp
        |-> $past(dln, 9) == 2'h0 && $past(dln, 10) != 2'h0)
        else $error("full-speed EOP SE0 width wrong");
    a_ls_eop_j: assert property ($fell(dev_oe) && dev_pu_dm
        |-> $past(dln, 26) == jst && $past(dln, 27) == 2'h0)
        else $error("low-speed EOP J width wrong");
    a_pullup_one: assert property (!$past(sys_rst_in) |-> dev_pu_dp != dev_pu_dm)
        else $error("idle polarity not one-hot");
    a_rst_se0_len: assert property ($fell(rem_oe) && !$past(rem_dp) && !$past(rem_dm)
        |-> run_q == RST_CYC)
        else $error("bus reset SE0 length wrong");

    // main traffic kinds
    c_dev_pkt: cover property ($rose(dev_oe));
    c_rem_pkt: cover property ($rose(rem_oe) && rem_dp != rem_dm);
    c_rem_rst: cover property ($fell(rem_oe) && run_q != 20'h0);
endmodule : lsl_link_checker

// file: dv/test_lowfull_speed_line_state_logic.sv
`timescale 1ns/1ps
module test_lowfull_speed_line_state_logic;
    localparam int RST_N = 150;
    // one ordinary case: kind 0 remote pkt, 1 device pkt, 2 keep-alive, 3 bus reset
    typedef struct packed {
        logic [1:0] kind;
        logic       low;
        logic       lsr;
        logic [7:0] syms;
        logic [3:0] n;
        logic [3:0] exp;
    } lsl_row_type;
    lsl_row_type rows [8] = '{
        '{2'h0, 1'h0, 1'h0, 8'h5a, 4'h8, 4'hc}, '{2'h1, 1'h0, 1'h0, 8'h0f, 4'h4, 4'hc},
        '{2'h0, 1'h0, 1'h1, 8'h3c, 4'h3, 4'hc}, '{2'h0, 1'h1, 1'h0, 8'ha5, 4'h5, 4'hc},
        '{2'h1, 1'h1, 1'h0, 8'h81, 4'h2, 4'hc}, '{2'h2, 1'h1, 1'h0, 8'h00, 4'h0, 4'h2},
        '{2'h2, 1'h0, 1'h0, 8'h00, 4'h0, 4'h0}, '{2'h3, 1'h0, 1'h0, 8'h00, 4'h0, 4'h1}};
    logic                  clk_in = 1'b0;
    logic                  sys_rst_in = 1'b1;
    logic                  low = 1'b0;
    logic                  lsr = 1'b0;
    logic                  d_valid = 1'b0;
    logic                  d_sym = 1'b0;
    logic                  r_valid = 1'b0;
    logic                  r_sym = 1'b0;
    logic                  r_rst = 1'b0;
    logic                  r_ka = 1'b0;
    logic                  d_ack, d_busy, r_ack, r_busy, sop, eop, ka, brst, act;
    lsl_pkg::lsl_line_type d_state, r_state;
    logic [7:0]            cnt [4];
    logic                  se1, oe_p, chk_k;
    int                    bad_count = 0;
    int                    cmp_count = 0;

    always #12.5 clk_in = ~clk_in;

    lsl_link_if link ();
    lsl_dev_end lsl_dev_end_inst (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(link.dev_mp),
        .speed_low_in(low), .tx_valid_in(d_valid), .tx_sym_in(d_sym),
        .tx_ack_out(d_ack), .tx_busy_out(d_busy), .line_state_out(d_state),
        .rx_active_out(act), .rx_sop_out(sop), .rx_eop_out(eop),
        .keepalive_out(ka), .bus_reset_out(brst));
    lsl_rem_end #(.RST_CYC(RST_N)) lsl_rem_end_inst (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(link.rem_mp),
        .attached_low_in(low), .ls_rate_in(lsr), .tx_valid_in(r_valid),
        .tx_sym_in(r_sym), .reset_req_in(r_rst), .keepalive_req_in(r_ka),
        .tx_ack_out(r_ack), .tx_busy_out(r_busy), .line_state_out(r_state));
    lsl_link_checker #(.RST_CYC(RST_N)) lsl_link_checker_inst (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .dev_dp(link.dev_dp),
        .dev_dm(link.dev_dm), .dev_oe(link.dev_oe), .dev_pu_dp(link.dev_pu_dp),
        .dev_pu_dm(link.dev_pu_dm), .rem_dp(link.rem_dp), .rem_dm(link.rem_dm),
        .rem_oe(link.rem_oe));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // event counts (bus reset kept as a flag), and the first level of each packet in the kind 0 and 1 rows
    always @(posedge clk_in) begin
        if (sop === 1'b1) cnt[0]++;
        if (eop === 1'b1) cnt[1]++;
        if (ka === 1'b1) cnt[2]++;
        if (brst === 1'b1) cnt[3] = 8'h1;
        if (d_state === lsl_pkg::LSL_SE1) se1 = 1'b1;
        if (chk_k && (link.dev_oe | link.rem_oe) === 1'b1 && !oe_p) begin
            check({6'h0, link.dp, link.dm}, low ? 8'h2 : 8'h1);
        end
        oe_p = link.dev_oe | link.rem_oe;
    end

    // reset held three cycles; line state reads SE0 meanwhile
    task automatic do_reset();
        sys_rst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        check({6'h0, d_state}, 8'h0);
        sys_rst_in <= 1'b0;
    endtask : do_reset

    // one symbol per acknowledge; dropping valid closes the packet
    task automatic tx_pkt(input logic rem, input logic [7:0] syms, input logic [3:0] n);
        int k;
        for (int i = 0; i <= int'(n); i++) begin
            if (rem) begin
                r_valid <= (i < n);
                r_sym   <= syms[i % 8];
            end else begin
                d_valid <= (i < n);
                d_sym   <= syms[i % 8];
            end
            k = 0;
            do begin
                @(posedge clk_in);
                k++;
            end while (i < n && k < 200 && (rem ? r_ack : d_ack) !== 1'b1);
            if (k >= 200) begin
                bad_count++;
                complete_run();
            end
        end
    endtask : tx_pkt

    // bounded wait until neither end drives, then let the line settle
    task automatic wait_idle();
        int k;
        k = 0;
        repeat (3) @(posedge clk_in);
        while ((d_busy | r_busy) !== 1'b0 && k < 2000) begin
            @(posedge clk_in);
            k++;
        end
        if (k >= 2000) begin
            bad_count++;
            complete_run();
        end
        repeat (40) @(posedge clk_in);
    endtask : wait_idle

    initial begin
        chk_k = 1'b0;
        oe_p  = 1'b0;
        for (int r = 0; r < 8; r++) begin
            // speed changes only under reset, so no false start is seen
            @(posedge clk_in);
            low <= rows[r].low;
            lsr <= rows[r].lsr;
            do_reset();
            repeat (40) @(posedge clk_in);
            @(negedge clk_in);
            cnt   = '{default: 8'h0};
            chk_k = (rows[r].kind < 2'h2);
            @(posedge clk_in);
            if (rows[r].kind < 2'h2) begin
                tx_pkt(rows[r].kind == 2'h0, rows[r].syms, rows[r].n);
            end else begin
                r_rst <= (rows[r].kind == 2'h3);
                r_ka  <= (rows[r].kind == 2'h2);
                @(posedge clk_in);
                r_rst <= 1'b0;
                r_ka  <= 1'b0;
            end
            wait_idle();
            check(cnt[0], {7'h0, rows[r].exp[3]});
            check(cnt[1], {7'h0, rows[r].exp[2]});
            check(cnt[2], {7'h0, rows[r].exp[1]});
            check(cnt[3], {7'h0, rows[r].exp[0]});
            check({6'h0, d_state}, 8'h1);
            check({6'h0, r_state}, 8'h1);
            check({7'h0, act}, 8'h0);
            $display("row %0d done", r);
        end
        // both ends send at once with opposite symbols: the lines collide high
        @(negedge clk_in);
        se1 = 1'b0;
        @(posedge clk_in);
        fork
            tx_pkt(1'b0, 8'hff, 4'h2);
            tx_pkt(1'b1, 8'h00, 4'h2);
        join
        wait_idle();
        check({7'h0, se1}, 8'h1);
        $display("collision test done");
        complete_run();
    end
endmodule : test_lowfull_speed_line_state_logic

// file: verilog/lsl_dev_end.sv
`timescale 1ns/1ps
module lsl_dev_end (
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 sys_rst_in,
    // link
    lsl_link_if.dev_mp                link,
    // device speed type
    input  wire logic                 speed_low_in,
    // transmit symbols
    input  wire logic                 tx_valid_in,
    input  wire logic                 tx_sym_in,
    output logic                      tx_ack_out,
    output logic                      tx_busy_out,
    // receive state and events
    output lsl_pkg::lsl_line_type     line_state_out,
    output logic                      rx_active_out,
    output logic                      rx_sop_out,
    output logic                      rx_eop_out,
    output logic                      keepalive_out,
    output logic                      bus_reset_out
);

    // transmit state
    lsl_pkg::lsl_tx_type                  st_q, st_d;
    logic [lsl_pkg::CNT_W-1:0]            cnt_q, cnt_d;
    logic [1:0]                           bits_q, bits_d;
    logic                                 dp_q, dp_d;
    logic                                 dm_q, dm_d;
    logic                                 oe_q, oe_d;
    logic                                 ack_q, ack_d;
    logic                                 pu_dp_q, pu_dm_q;

    // receive state
    logic [1:0]                           s1_q, s2_q;
    lsl_pkg::lsl_line_type                line_q, line_d;
    logic [lsl_pkg::CNT_W-1:0]            se0_q, se0_d;
    logic [lsl_pkg::DET_CNT_W-1:0]        det_q, det_d;
    logic                                 pkt_q, pkt_d;
    logic                                 sop_q, sop_d;
    logic                                 eop_q, eop_d;
    logic                                 ka_q, ka_d;
    logic                                 brst_q, brst_d;

    // shared timing terms
    logic                                 tick;
    logic [lsl_pkg::CNT_W-1:0]            bit_cyc;
    logic [lsl_pkg::CNT_W-1:0]            bit_rl;

    // a device is its own attached type: one speed sets both rate and polarity
    assign bit_cyc = lsl_pkg::lsl_bit_cyc(speed_low_in);
    assign bit_rl  = bit_cyc - 5'h01;
    assign tick    = (cnt_q == 5'h00);

    // transmit sequencer next state
    // first bit is an automatic K so the line leaves idle at once
    always_comb begin
        st_d   = st_q;
        cnt_d  = tick ? cnt_q : cnt_q - 5'h01;
        bits_d = bits_q;
        dp_d   = dp_q;
        dm_d   = dm_q;
        oe_d   = oe_q;
        ack_d  = 1'b0;
        case (st_q)
            lsl_pkg::TX_IDLE: begin
                oe_d = 1'b0;
                if (tx_valid_in) begin
                    st_d         = lsl_pkg::TX_DATA;
                    cnt_d        = bit_rl;
                    oe_d         = 1'b1;
                    {dp_d, dm_d} = lsl_pkg::lsl_drive(lsl_pkg::LSL_K, speed_low_in);
                end
            end
            lsl_pkg::TX_DATA: begin
                if (tick && tx_valid_in) begin
                    // symbol taken at the bit boundary, acked next cycle
                    cnt_d        = bit_rl;
                    ack_d        = 1'b1;
                    {dp_d, dm_d} = lsl_pkg::lsl_drive(tx_sym_in ? lsl_pkg::LSL_J :
                                                      lsl_pkg::LSL_K,
                                                      speed_low_in);
                end else if (tick) begin
                    // no symbol ready: the packet ends here
                    st_d         = lsl_pkg::TX_SE0;
                    cnt_d        = bit_rl;
                    bits_d       = lsl_pkg::EOP_SE0_BITS - 2'h1;
                    {dp_d, dm_d} = 2'h0;
                end
            end
            lsl_pkg::TX_SE0: begin
                if (tick && bits_q == 2'h0) begin
                    // J tail is one bit of this buffer's own speed
                    st_d         = lsl_pkg::TX_J;
                    cnt_d        = bit_rl;
                    bits_d       = lsl_pkg::EOP_J_BITS - 2'h1;
                    {dp_d, dm_d} = lsl_pkg::lsl_drive(lsl_pkg::LSL_J, speed_low_in);
                end else if (tick) begin
                    bits_d = bits_q - 2'h1;
                    cnt_d  = bit_rl;
                end
            end
            lsl_pkg::TX_J: begin
                if (tick) begin
                    st_d = lsl_pkg::TX_IDLE;
                    oe_d = 1'b0;
                end
            end
            default: begin
                st_d = lsl_pkg::TX_IDLE;
                oe_d = 1'b0;
            end
        endcase
    end

    // transmit registers; pull-up marks speed: D+ full, D- low
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_q    <= lsl_pkg::TX_IDLE;
            cnt_q   <= '0;
            bits_q  <= 2'h0;
            dp_q    <= 1'b0;
            dm_q    <= 1'b0;
            oe_q    <= 1'b0;
            ack_q   <= 1'b0;
            pu_dp_q <= 1'b0;
            pu_dm_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            bits_q  <= bits_d;
            dp_q    <= dp_d;
            dm_q    <= dm_d;
            oe_q    <= oe_d;
            ack_q   <= ack_d;
            pu_dp_q <= ~speed_low_in;
            pu_dm_q <= speed_low_in;
        end
    end

    // receive next state: decode, framing and reset detection
    // own transmissions echo back here too, which gives a loopback view
    always_comb begin
        line_d  = lsl_pkg::lsl_decode(s2_q[1], s2_q[0], speed_low_in);
        se0_d   = se0_q;
        det_d   = det_q;
        pkt_d   = pkt_q;
        sop_d   = 1'b0;
        eop_d   = 1'b0;
        ka_d    = 1'b0;
        brst_d  = brst_q;
        // saturating SE0 run length, in cycles
        if (line_d != lsl_pkg::LSL_SE0) begin
            se0_d = '0;
        end else if (se0_q != '1) begin
            se0_d = se0_q + 5'h01;
        end
        if (line_d == lsl_pkg::LSL_J && line_q == lsl_pkg::LSL_SE0 &&
            se0_q >= bit_cyc * 5'(lsl_pkg::EOP_RX_SE0_BITS)) begin
            // SE0 long enough then J: packet end, or keep-alive if no packet and low speed
            pkt_d = 1'b0;
            eop_d = pkt_q;
            ka_d  = ~pkt_q & speed_low_in;
        end else if (line_d == lsl_pkg::LSL_K && line_q == lsl_pkg::LSL_J && !pkt_q) begin
            pkt_d = 1'b1;
            sop_d = 1'b1;
        end
        // long SE0 is a bus reset; wide counter avoids a false hit on EOP
        if (line_d != lsl_pkg::LSL_SE0) begin
            det_d  = '0;
            brst_d = 1'b0;
        end else if (det_q == lsl_pkg::RST_DET_CYC) begin
            brst_d = 1'b1;
            pkt_d  = 1'b0;
        end else begin
            det_d = det_q + 8'h01;
        end
    end

    // receive registers; s1_q feeds only s2_q
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s1_q   <= 2'h0;
            s2_q   <= 2'h0;
            line_q <= lsl_pkg::LSL_SE0;
            se0_q  <= '0;
            det_q  <= '0;
            pkt_q  <= 1'b0;
            sop_q  <= 1'b0;
            eop_q  <= 1'b0;
            ka_q   <= 1'b0;
            brst_q <= 1'b0;
        end else begin
            s1_q   <= {link.dp, link.dm};
            s2_q   <= s1_q;
            line_q <= line_d;
            se0_q  <= se0_d;
            det_q  <= det_d;
            pkt_q  <= pkt_d;
            sop_q  <= sop_d;
            eop_q  <= eop_d;
            ka_q   <= ka_d;
            brst_q <= brst_d;
        end
    end

    // outputs, all straight from registers
    assign link.dev_dp    = dp_q;
    assign link.dev_dm    = dm_q;
    assign link.dev_oe    = oe_q;
    assign link.dev_pu_dp = pu_dp_q;
    assign link.dev_pu_dm = pu_dm_q;
    assign tx_ack_out     = ack_q;
    assign tx_busy_out    = oe_q;
    assign line_state_out = line_q;
    assign rx_active_out  = pkt_q;
    assign rx_sop_out     = sop_q;
    assign rx_eop_out     = eop_q;
    assign keepalive_out  = ka_q;
    assign bus_reset_out  = brst_q;

endmodule : lsl_dev_end

// file: verilog/lsl_link_if.sv
`timescale 1ns/1ps
interface lsl_link_if;
    // device end drive and pull-ups
    logic dev_dp;
    logic dev_dm;
    logic dev_oe;
    logic dev_pu_dp;
    logic dev_pu_dm;
    // remote end drive
    logic rem_dp;
    logic rem_dm;
    logic rem_oe;
    // resolved line levels
    logic dp;
    logic dm;

    // a driver wins over the pull-up; undriven lines rest at the device's idle
    assign dp = (dev_oe & dev_dp) | (rem_oe & rem_dp) | (~dev_oe & ~rem_oe & dev_pu_dp);
    assign dm = (dev_oe & dev_dm) | (rem_oe & rem_dm) | (~dev_oe & ~rem_oe & dev_pu_dm);

    modport dev_mp (
        output dev_dp,
        output dev_dm,
        output dev_oe,
        output dev_pu_dp,
        output dev_pu_dm,
        input  dp,
        input  dm
    );

    modport rem_mp (
        output rem_dp,
        output rem_dm,
        output rem_oe,
        input  dp,
        input  dm
    );
endinterface : lsl_link_if

// file: verilog/lsl_pkg.sv
package lsl_pkg;

    // decoded state of the two data lines
    typedef enum logic [1:0] {
        LSL_SE0,
        LSL_J,
        LSL_K,
        LSL_SE1
    } lsl_line_type;

    // transmitter sequencing, shared by both ends
    typedef enum logic [2:0] {
        TX_IDLE,
        TX_DATA,
        TX_SE0,
        TX_J,
        TX_RST
    } lsl_tx_type;

    // clock and bit periods, in picoseconds
    localparam int CLK_PS    = 25000;
    localparam int FS_BIT_PS = 83333;
    localparam int LS_BIT_PS = 666667;

    // bit periods in clock cycles; rounded down, a bit time is approximate anyway
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FS_BIT_CYC = CNT_W'(FS_BIT_PS / CLK_PS);
    localparam logic [CNT_W-1:0] LS_BIT_CYC = CNT_W'(LS_BIT_PS / CLK_PS);

    // end-of-packet shape in bit times
    localparam logic [1:0] EOP_SE0_BITS    = 2'h2;
    localparam logic [1:0] EOP_J_BITS      = 2'h1;
    localparam logic [1:0] EOP_RX_SE0_BITS = 2'h1;

    // bus reset: least drive time, and receiver detection threshold, in ns
    localparam int CLK_NS     = 25;
    localparam int RST_NS     = 10000000;
    localparam int RST_CYC    = (RST_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_DET_NS = 2500;
    localparam int RST_CNT_W  = 19;
    localparam int DET_CNT_W  = 8;
    localparam logic [DET_CNT_W-1:0] RST_DET_CYC =
        DET_CNT_W'((RST_DET_NS + CLK_NS - 1) / CLK_NS);

    // cycles in one bit time at the given rate
    function automatic logic [CNT_W-1:0] lsl_bit_cyc(input logic low);
        return low ? LS_BIT_CYC : FS_BIT_CYC;
    endfunction : lsl_bit_cyc

    // line pair to state; idle reads as J and resume as K
    function automatic lsl_line_type lsl_decode(input logic dp, input logic dm,
                                                input logic low);
        if (dp && dm) begin
            return LSL_SE1;
        end else if (!dp && !dm) begin
            return LSL_SE0;
        end else if (dp) begin
            return low ? LSL_K : LSL_J;
        end else begin
            return low ? LSL_J : LSL_K;
        end
    endfunction : lsl_decode

    // state to line pair {dp, dm}; J is differential 1 at full speed
    function automatic logic [1:0] lsl_drive(input lsl_line_type st, input logic low);
        case (st)
            LSL_J:   return low ? 2'h1 : 2'h2;
            LSL_K:   return low ? 2'h2 : 2'h1;
            LSL_SE1: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction : lsl_drive

endpackage : lsl_pkg

// file: verilog/lsl_rem_end.sv
`timescale 1ns/1ps
module lsl_rem_end #(
    parameter int RST_CYC = lsl_pkg::RST_CYC
) (
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 sys_rst_in,
    // link
    lsl_link_if.rem_mp                link,
    // port configuration
    input  wire logic                 attached_low_in,
    input  wire logic                 ls_rate_in,
    // transmit requests
    input  wire logic                 tx_valid_in,
    input  wire logic                 tx_sym_in,
    input  wire logic                 reset_req_in,
    input  wire logic                 keepalive_req_in,
    output logic                      tx_ack_out,
    output logic                      tx_busy_out,
    // receive
    output lsl_pkg::lsl_line_type     line_state_out
);

    lsl_pkg::lsl_tx_type                  st_q, st_d;
    logic [lsl_pkg::CNT_W-1:0]            cnt_q, cnt_d;
    logic [lsl_pkg::RST_CNT_W-1:0]        rcnt_q, rcnt_d;
    logic [1:0]                           bits_q, bits_d;
    logic                                 ka_q, ka_d;
    logic                                 dp_q, dp_d, dm_q, dm_d, oe_q, oe_d;
    logic                                 ack_q, ack_d;
    logic [1:0]                           s1_q, s2_q;
    lsl_pkg::lsl_line_type                line_q, line_d;
    logic                                 pol_low, rate_low, tick;
    logic [lsl_pkg::CNT_W-1:0]            rate_rl, jbit_rl;

    // polarity follows the attached device only; rate may be slower
    assign pol_low  = attached_low_in;
    assign rate_low = attached_low_in | ls_rate_in | ka_q;
    assign rate_rl  = lsl_pkg::lsl_bit_cyc(rate_low) - 5'h01;
    assign jbit_rl  = lsl_pkg::lsl_bit_cyc(pol_low) - 5'h01;
    assign tick     = (cnt_q == 5'h00);

    // transmit sequencer next state
    always_comb begin
        st_d   = st_q;
        cnt_d  = tick ? cnt_q : cnt_q - 5'h01;
        rcnt_d = rcnt_q;
        bits_d = bits_q;
        ka_d   = ka_q;
        dp_d   = dp_q;
        dm_d   = dm_q;
        oe_d   = oe_q;
        ack_d  = 1'b0;
        case (st_q)
            lsl_pkg::TX_IDLE: begin
                oe_d = 1'b0;
                if (reset_req_in) begin
                    st_d           = lsl_pkg::TX_RST;
                    rcnt_d         = lsl_pkg::RST_CNT_W'(RST_CYC - 1);
                    {dp_d, dm_d}   = 2'h0;
                    oe_d           = 1'b1;
                end else if (keepalive_req_in) begin
                    st_d           = lsl_pkg::TX_SE0;
                    ka_d           = 1'b1;
                    bits_d         = lsl_pkg::EOP_SE0_BITS - 2'h1;
                    cnt_d          = lsl_pkg::LS_BIT_CYC - 5'h01;
                    {dp_d, dm_d}   = 2'h0;
                    oe_d           = 1'b1;
                end else if (tx_valid_in) begin
                    st_d           = lsl_pkg::TX_DATA;
                    cnt_d          = rate_rl;
                    {dp_d, dm_d}   = lsl_pkg::lsl_drive(lsl_pkg::LSL_K, pol_low);
                    oe_d           = 1'b1;
                end
            end
            lsl_pkg::TX_DATA: begin
                if (tick && tx_valid_in) begin
                    cnt_d        = rate_rl;
                    ack_d        = 1'b1;
                    {dp_d, dm_d} = lsl_pkg::lsl_drive(tx_sym_in ? lsl_pkg::LSL_J :
                                                      lsl_pkg::LSL_K, pol_low);
                end else if (tick) begin
                    st_d         = lsl_pkg::TX_SE0;
                    cnt_d        = rate_rl;
                    bits_d       = lsl_pkg::EOP_SE0_BITS - 2'h1;
                    {dp_d, dm_d} = 2'h0;
                end
            end
            lsl_pkg::TX_SE0: begin
                if (tick && bits_q == 2'h0) begin
                    st_d         = lsl_pkg::TX_J;
                    cnt_d        = jbit_rl;
                    {dp_d, dm_d} = lsl_pkg::lsl_drive(lsl_pkg::LSL_J, pol_low);
                end else if (tick) begin
                    bits_d = bits_q - 2'h1;
                    cnt_d  = rate_rl;
                end
            end
            lsl_pkg::TX_J: begin
                if (tick) begin
                    st_d = lsl_pkg::TX_IDLE;
                    ka_d = 1'b0;
                    oe_d = 1'b0;
                end
            end
            default: begin
                // bus reset: hold SE0 for the full count
                if (rcnt_q == '0) begin
                    st_d = lsl_pkg::TX_IDLE;
                    oe_d = 1'b0;
                end else begin
                    rcnt_d = rcnt_q - 1'b1;
                end
            end
        endcase
    end

    // line observer; polarity per attached device
    always_comb begin
        line_d = lsl_pkg::lsl_decode(s2_q[1], s2_q[0], pol_low);
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_q   <= lsl_pkg::TX_IDLE;
            cnt_q  <= '0;
            rcnt_q <= '0;
            bits_q <= 2'h0;
            ka_q   <= 1'b0;
            dp_q   <= 1'b0;
            dm_q   <= 1'b0;
            oe_q   <= 1'b0;
            ack_q  <= 1'b0;
            s1_q   <= 2'h0;
            s2_q   <= 2'h0;
            line_q <= lsl_pkg::LSL_SE0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            rcnt_q <= rcnt_d;
            bits_q <= bits_d;
            ka_q   <= ka_d;
            dp_q   <= dp_d;
            dm_q   <= dm_d;
            oe_q   <= oe_d;
            ack_q  <= ack_d;
            s1_q   <= {link.dp, link.dm};
            s2_q   <= s1_q;
            line_q <= line_d;
        end
    end

    assign link.rem_dp    = dp_q;
    assign link.rem_dm    = dm_q;
    assign link.rem_oe    = oe_q;
    assign tx_ack_out     = ack_q;
    assign tx_busy_out    = oe_q;
    assign line_state_out = line_q;

endmodule : lsl_rem_end
